// *** dppg_pkg.sv ***
// constants for the doze clock divider and peripheral power gate block
// assumes a single system clock and a simple strobe register port
// ============================================================
// Behaviour
// R1 - during doze the system and peripheral clocks stay full rate; only core slows
// R2 - core slow clock is an enable aligned to the full-rate clock domain
// R3 - writing cpu_slow_enable (bit 11) to one starts doze
// R4 - cpu_clock_ratio bits 14:12 pick eight ratios 1:1 to 1:128, default 1:1
// R5 - ratio codes 0..7 give core divisors 1,2,4,...,128
// R6 - restore_on_irq (bit 15) set returns core to full speed on interrupt
// R7 - restore_on_irq resets to zero; while zero interrupts leave doze alone
// R8 - interrupt in doze with restore_on_irq set clears cpu_slow_enable
// R9 - communication and clock modules have module_on at bit 15; clock keeps running
// R10 - timers use timer_run and converter uses converter_on the same way
// R11 - ports, change notification and capture have no module_on bit
// R12 - every peripheral but ports has a module_power_cut bit; one disables it
// R13 - power-cut peripheral loses all clocks and register access
// R14 - module_on cleared still allows configuration writes and buffer preload
// R15 - reads of a power-cut peripheral return zero and writes are dropped
// R16 - halt_when_idle (bit 13) stops the peripheral during idle mode
// R17 - modules without module_on still have halt_when_idle
// R18 - real-time clock has no halt_when_idle and runs through idle
// R19 - after deep sleep only the two retained scratch registers keep contents
// R20 - deep sleep wake source is recorded in wake_cause and reset_cause
// R21 - reset_cause reset value depends on the type of reset
// R22 - software enables wake interrupt sources before sleeping
package dppg_pkg;
  // ============================================================
  // register addresses (word index)
  localparam logic [3:0] ADDR_RESET_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_DIVIDE_CONTROL      = 4'h1;
  localparam logic [3:0] ADDR_POWER_CUT   = 4'h2;
  localparam logic [3:0] ADDR_DS_CONTROL  = 4'h3;
  localparam logic [3:0] ADDR_WAKE_CAUSE  = 4'h4;
  localparam logic [3:0] ADDR_SCRATCH0    = 4'h5;
  localparam logic [3:0] ADDR_SCRATCH1    = 4'h6;
  localparam logic [3:0] ADDR_PERIPH_BASE = 4'h8; // 8..15 peripheral control windows
  // ============================================================
  // field layout
  localparam int CLOCK_DIVIDE_CONTROL_ROI_BIT   = 15;
  localparam int CLOCK_DIVIDE_CONTROL_RATIO_HI  = 14;
  localparam int CLOCK_DIVIDE_CONTROL_RATIO_LO  = 12;
  localparam int CLOCK_DIVIDE_CONTROL_CPU_SLOW_ENABLE_BIT = 11;
  localparam int CLOCK_DIVIDE_CONTROL_RC_HI     = 10;
  localparam int CLOCK_DIVIDE_CONTROL_RC_LO     = 8;
  localparam int CTRL_ON_BIT      = 15;
  localparam int CTRL_IDLE_BIT    = 13;
  localparam int DEEP_SLEEP_CONTROL_EN_BIT     = 15;
  localparam int DEEP_SLEEP_CONTROL_REL_BIT    = 0;
  // ============================================================
  // reset values and masks
  localparam logic [15:0] CLOCK_DIVIDE_CONTROL_RESET  = 16'h0300;
  localparam logic [15:0] CLOCK_DIVIDE_CONTROL_MASK   = 16'hFF00;
  localparam logic [15:0] PMD_RESET     = 16'h0000;
  localparam logic [15:0] RESET_CAUSE_MASK     = 16'hE5FF;
  localparam logic [15:0] RESET_CAUSE_POR_VAL  = 16'h0003;
  localparam logic [15:0] RESET_CAUSE_EXT_VAL  = 16'h0080;
  localparam logic [15:0] RESET_CAUSE_DS_FLAG  = 16'h0400;
  localparam logic [15:0] DEEP_SLEEP_CONTROL_MASK    = 16'h8003;
  localparam logic [15:0] WAKE_MASK     = 16'h019D;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [7:0]  DIV_MAX       = 8'h7F;
  // ============================================================
  // peripheral kinds
  typedef enum logic [3:0] {
    DPPG_K_COMM  = 4'b0001,  // serial or parallel link, has module_on
    DPPG_K_TIMER = 4'b0010,  // has timer_run / converter_on
    DPPG_K_RTC   = 4'b0100,  // module_on, never halts in idle
    DPPG_K_AUX   = 4'b1000   // capture / change notify: no module_on
  } dppg_kind_t;
  // reset kinds
  typedef enum logic [2:0] {
    DPPG_RST_POR  = 3'b001,
    DPPG_RST_EXT  = 3'b010,
    DPPG_RST_DSW  = 3'b100
  } dppg_rst_t;
endpackage : dppg_pkg

// *** dppg_power_gate.sv ***
// doze divider, peripheral power cut and idle gating, low-power registers
// assumes synchronous inputs and a strobe register port with one-cycle read data
//
// The placing of the registers and the strobed register port were left to the implementer.
module dppg_power_gate
  import dppg_pkg::*;
#(
  parameter int NPER = 8,
  parameter logic [4*NPER-1:0] KINDS = {4'h8, 4'h8, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1}
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  // reset kind seen at release, wake sources
  input  wire logic [2:0]      reset_kind,
  input  wire logic            ds_wake_valid,
  input  wire logic [15:0]     ds_wake_bits,
  // core state
  input  wire logic            irq_event,
  input  wire logic            idle_mode,
  // register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [15:0]     reg_wdata,
  input  wire logic            reg_write,
  input  wire logic            reg_read,
  output logic      [15:0]     reg_rdata,
  // clock gating and deep sleep outputs
  output logic                 core_clk_en,
  output logic                 periph_clk_en,
  output logic      [NPER-1:0] periph_clk_on,
  output logic      [NPER-1:0] periph_run,
  output logic                 ds_enter
);
  logic [15:0]      clock_divide_control;
  logic [15:0]      power_cut;
  logic [15:0]      reset_cause;
  logic [15:0]      ds_control;
  logic [15:0]      wake_cause;
  logic [15:0]      scratch0;
  logic [15:0]      scratch1;
  logic [15:0]      pctrl [NPER];
  logic [7:0]       div_cnt;
  logic [7:0]       div_lim;
  logic             caught;
  logic             slow_on;
  logic             periph_hit;
  logic [2:0]       pidx;

  assign slow_on = clock_divide_control[CLOCK_DIVIDE_CONTROL_CPU_SLOW_ENABLE_BIT];
  // decode of the peripheral window
  assign periph_hit = reg_addr[3];
  assign pidx       = reg_addr[2:0];

  // ============================================================
  // doze divider
  // core enable is a pulse on the full-rate clock, so both domains share edges
  assign div_lim = slow_on ? ((8'h01 << clock_divide_control[CLOCK_DIVIDE_CONTROL_RATIO_HI:CLOCK_DIVIDE_CONTROL_RATIO_LO]) - 8'h01)
                           : 8'h00; // R4 R5
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
    end else if (div_cnt >= div_lim) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign core_clk_en   = (div_cnt >= div_lim); // R2
  assign periph_clk_en = 1'b1; // R1

  // ============================================================
  // clock divider control register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clock_divide_control <= CLOCK_DIVIDE_CONTROL_RESET; // R4 R7
    end else begin
      if (reg_write && reg_addr == ADDR_CLOCK_DIVIDE_CONTROL) begin
        clock_divide_control <= reg_wdata & CLOCK_DIVIDE_CONTROL_MASK; // R3
      end
      // hardware clear beats a same-cycle software write
      if (irq_event && clock_divide_control[CLOCK_DIVIDE_CONTROL_ROI_BIT] && slow_on) begin
        clock_divide_control[CLOCK_DIVIDE_CONTROL_CPU_SLOW_ENABLE_BIT] <= 1'b0; // R6 R8
      end
    end
  end

  // ============================================================
  // power cut bank
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      power_cut <= PMD_RESET;
    end else if (reg_write && reg_addr == ADDR_POWER_CUT) begin
      power_cut <= reg_wdata; // R12
    end
  end

  // ============================================================
  // peripheral control windows: one generate slice per peripheral
  for (genvar i = 0; i < NPER; i++) begin : g_per
    localparam logic [3:0] KIND = KINDS[4*i +: 4];
    logic cut;
    logic has_on;
    logic has_idle;
    assign has_on   = (KIND != DPPG_K_AUX); // R11
    assign has_idle = (KIND != DPPG_K_RTC); // R17 R18
    assign cut      = power_cut[i]; // R12
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        pctrl[i] <= ZERO16;
      end else if (cut) begin
        pctrl[i] <= ZERO16; // R13
      end else if (reg_write && periph_hit && pidx == 3'(i)) begin
        // writes land even while module_on is clear
        pctrl[i] <= reg_wdata; // R14 R15
      end
    end
    assign periph_clk_on[i] = !cut; // R13
    assign periph_run[i] = !cut
        && (!has_on || pctrl[i][CTRL_ON_BIT]) // R9 R10
        && !(has_idle && idle_mode && pctrl[i][CTRL_IDLE_BIT]); // R16
  end

  // ============================================================
  // reset cause: value chosen by reset kind after release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      caught <= 1'b0;
      reset_cause <= ZERO16;
    end else if (!caught) begin
      caught <= 1'b1;
      case (reset_kind)
        DPPG_RST_POR: reset_cause <= RESET_CAUSE_POR_VAL; // R21
        DPPG_RST_EXT: reset_cause <= RESET_CAUSE_EXT_VAL;
        DPPG_RST_DSW: reset_cause <= RESET_CAUSE_DS_FLAG; // R20
        default:      reset_cause <= ZERO16;
      endcase
    end else if (reg_write && reg_addr == ADDR_RESET_CAUSE) begin
      reset_cause <= reg_wdata & RESET_CAUSE_MASK;
    end
  end

  // ============================================================
  // wake cause: hardware set wins over software clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wake_cause <= ZERO16;
    end else begin
      if (ds_wake_valid) begin
        wake_cause <= (wake_cause | ds_wake_bits) & WAKE_MASK; // R20
      end else if (reg_write && reg_addr == ADDR_WAKE_CAUSE) begin
        wake_cause <= reg_wdata & WAKE_MASK;
      end
    end
  end

  // ============================================================
  // deep sleep control, enable self-clears on wake
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ds_control <= ZERO16;
    end else if (ds_wake_valid) begin
      ds_control <= (ds_control & ~(16'h0001 << DEEP_SLEEP_CONTROL_EN_BIT)) | (16'h0001 << DEEP_SLEEP_CONTROL_REL_BIT);
    end else if (reg_write && reg_addr == ADDR_DS_CONTROL) begin
      ds_control <= reg_wdata & DEEP_SLEEP_CONTROL_MASK;
    end
  end
  assign ds_enter = ds_control[DEEP_SLEEP_CONTROL_EN_BIT];

  // ============================================================
  // retained scratch: no reset, so contents survive the deep sleep reset
  always_ff @(posedge clk_sys) begin
    if (reg_write && reg_addr == ADDR_SCRATCH0) begin
      scratch0 <= reg_wdata; // R19
    end
    if (reg_write && reg_addr == ADDR_SCRATCH1) begin
      scratch1 <= reg_wdata; // R19
    end
  end

  // ============================================================
  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= ZERO16;
    end else if (reg_read) begin
      if (periph_hit) begin
        reg_rdata <= power_cut[pidx] ? ZERO16 : pctrl[pidx]; // R15
      end else begin
        case (reg_addr)
          ADDR_RESET_CAUSE: reg_rdata <= reset_cause;
          ADDR_CLOCK_DIVIDE_CONTROL:      reg_rdata <= clock_divide_control;
          ADDR_POWER_CUT:   reg_rdata <= power_cut;
          ADDR_DS_CONTROL:  reg_rdata <= ds_control;
          ADDR_WAKE_CAUSE:  reg_rdata <= wake_cause;
          ADDR_SCRATCH0:    reg_rdata <= scratch0;
          ADDR_SCRATCH1:    reg_rdata <= scratch1;
          default:          reg_rdata <= ZERO16;
        endcase
      end
    end else begin
      reg_rdata <= ZERO16;
    end
  end
endmodule // dppg_power_gate

// *** dppg_props.sv ***
// port checker for the power gate block
// assumes default peripheral kinds: index 5 is the clock module
module dppg_props #(
  parameter int NPER = 8
) (
  // clock and reset
  input wire logic            clk_sys,
  input wire logic            resetn,
  // inputs
  input wire logic            ds_wake_valid,
  input wire logic            irq_event,
  input wire logic            idle_mode,
  input wire logic [3:0]      reg_addr,
  input wire logic [15:0]     reg_wdata,
  input wire logic            reg_write,
  input wire logic            reg_read,
  // outputs
  input wire logic [15:0]     reg_rdata,
  input wire logic            core_clk_en,
  input wire logic            periph_clk_en,
  input wire logic [NPER-1:0] periph_clk_on,
  input wire logic [NPER-1:0] periph_run,
  input wire logic            ds_enter
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ============================================================
  // doze writes
  sequence s_div2;
    reg_write && reg_addr == 4'h1 && reg_wdata[15:11] == 5'b00011;
  endsequence
  sequence s_roi;
    reg_write && reg_addr == 4'h1 && reg_wdata[15:11] == 5'b11111;
  endsequence
  // ============================================================
  // assertions
  periph_clk_a: assert property (periph_clk_en)
    else $error("peripheral clock gated");
  cut_run_a: assert property ((periph_run & ~periph_clk_on) == '0)
    else $error("unclocked peripheral running");
  unmapped_a: assert property (reg_read && reg_addr == 4'h7 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  cut_read_a: assert property (reg_read && reg_addr[3] && !periph_clk_on[reg_addr[2:0]]
    |=> reg_rdata == 16'h0000)
    else $error("cut peripheral read not zero");
  doze_off_a: assert property (reg_write && reg_addr == 4'h1 && !reg_wdata[11] |=> core_clk_en)
    else $error("core slowed without doze");
  doze_div_a: assert property (s_div2 ##1 !reg_write [*2] |-> core_clk_en != $past(core_clk_en))
    else $error("divide by two not alternating");
  roi_clear_a: assert property (s_roi ##1 !reg_write ##1 (irq_event && !reg_write)
    |=> core_clk_en)
    else $error("interrupt left core slow");
  idle_rtc_a: assert property ($changed(idle_mode) && !$past(reg_write)
    |-> $stable(periph_run[5]))
    else $error("clock module affected by idle");
  wake_a: assert property (ds_wake_valid |=> !ds_enter)
    else $error("deep sleep enable kept after wake");
endmodule // dppg_props
bind dppg_power_gate dppg_props #(.NPER(NPER)) i_props (.clk_sys(clk_sys), .resetn(resetn),
  .ds_wake_valid(ds_wake_valid), .irq_event(irq_event), .idle_mode(idle_mode),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
  .periph_clk_on(periph_clk_on), .periph_run(periph_run), .ds_enter(ds_enter));

// *** dppg_core_model.sv ***
// core side model: interrupt source, idle request, core tick counter
// assumes the same system clock as the power gate
module dppg_core_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // bench requests
  input  wire logic        irq_req,
  input  wire logic        idle_req,
  // power gate side
  input  wire logic        core_clk_en,
  output logic             irq_event,
  output logic             idle_mode,
  output logic [15:0]      core_ticks
);
  timeunit 1ns;
  timeprecision 1ns;
  // wake source is enabled ahead of time, so each request gives one event
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_event <= 1'b0;
      idle_mode <= 1'b0;
    end else begin
      irq_event <= irq_req;
      idle_mode <= idle_req;
    end
  end
  // core only advances on enabled system clock edges
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) core_ticks <= 16'h0000;
    else if (core_clk_en) core_ticks <= core_ticks + 16'h0001;
  end
endmodule // dppg_core_model

// *** test_doze_and_peripheral_power_gate.sv ***
// self-checking bench for the power gate block
// assumes default kinds: 0-2 link, 3-4 timer, 5 clock, 6-7 auxiliary
module test_doze_and_peripheral_power_gate;
  import dppg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} dppg_row_t;
  logic       clk_sys, resetn, ds_wake_valid, irq_event, idle_mode, reg_write, reg_read;
  logic       core_clk_en, periph_clk_en, ds_enter, irq_req, idle_req;
  logic [2:0] reset_kind;
  logic [3:0] reg_addr;
  logic [7:0] periph_clk_on, periph_run;
  logic [15:0] ds_wake_bits, reg_wdata, reg_rdata, core_ticks, t0;
  int         n_fail = 0, num_checks = 0;
  dppg_row_t  rows [8];
  dppg_power_gate i_dut (.clk_sys(clk_sys), .resetn(resetn), .reset_kind(reset_kind),
    .ds_wake_valid(ds_wake_valid), .ds_wake_bits(ds_wake_bits), .irq_event(irq_event),
    .idle_mode(idle_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .periph_clk_on(periph_clk_on), .periph_run(periph_run),
    .ds_enter(ds_enter));
  dppg_core_model i_core (.clk_sys(clk_sys), .resetn(resetn), .irq_req(irq_req),
    .idle_req(idle_req), .core_clk_en(core_clk_en), .irq_event(irq_event),
    .idle_mode(idle_mode), .core_ticks(core_ticks));
  // ============================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes start one edge late so back-to-back calls never clash
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic pulse_irq;
    irq_req <= 1'b1;
    @(posedge clk_sys);
    irq_req <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ============================================================
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #200_000;
    n_fail++;
    conclude;
  end
  // ============================================================
  // main sequence
  initial begin
    {resetn, ds_wake_valid, reg_write, reg_read, irq_req, idle_req} = '0;
    {reg_addr, reg_wdata, ds_wake_bits} = '0;
    reset_kind = 3'b001;
    rows[0] = '{ADDR_CLOCK_DIVIDE_CONTROL, 16'h0800, 16'h0800};
    rows[1] = '{ADDR_CLOCK_DIVIDE_CONTROL, 16'h70FF, 16'h7000};
    rows[2] = '{ADDR_POWER_CUT, 16'h00FF, 16'h00FF};
    rows[3] = '{ADDR_POWER_CUT, 16'h0000, 16'h0000};
    rows[4] = '{ADDR_SCRATCH0, 16'hA5A5, 16'hA5A5};
    rows[5] = '{ADDR_SCRATCH1, 16'h5A5A, 16'h5A5A};
    rows[6] = '{4'h7, 16'hFFFF, 16'h0000};
    rows[7] = '{4'h9, 16'h2000, 16'h2000};
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(ADDR_RESET_CAUSE, 16'h0003);
    rd(ADDR_CLOCK_DIVIDE_CONTROL, 16'h0300);
    rd(ADDR_POWER_CUT, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // every ratio code, counted over a window all divisors fit into
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CLOCK_DIVIDE_CONTROL, {1'b0, 3'(k), 12'h800});
      @(posedge clk_sys);
      #1 t0 = core_ticks;
      repeat (256) @(posedge clk_sys);
      #1 chk(core_ticks - t0, 16'(256 >> k));
    end
    wr(ADDR_CLOCK_DIVIDE_CONTROL, 16'hF800);
    pulse_irq;
    rd(ADDR_CLOCK_DIVIDE_CONTROL, 16'hF000);
    wr(ADDR_CLOCK_DIVIDE_CONTROL, 16'h7800);
    pulse_irq;
    rd(ADDR_CLOCK_DIVIDE_CONTROL, 16'h7800);
    wr(4'h8, 16'h8000);
    #1 chk(16'(periph_run), 16'h00C1);
    wr(ADDR_POWER_CUT, 16'h0001);
    #1 chk(16'(periph_clk_on), 16'h00FE);
    rd(4'h8, 16'h0000);
    wr(4'h8, 16'h8000);
    wr(ADDR_POWER_CUT, 16'h0000);
    rd(4'h8, 16'h0000);
    wr(4'h8, 16'hA000);
    wr(4'hD, 16'hA000);
    wr(4'hE, 16'h2000);
    #1 chk(16'(periph_run), 16'h00E1);
    @(posedge clk_sys);
    idle_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk(16'(periph_run), 16'h00A0);
    wr(ADDR_DS_CONTROL, 16'h8000);
    #1 chk(16'(ds_enter), 16'h0001);
    @(posedge clk_sys);
    ds_wake_bits <= 16'h0008;
    ds_wake_valid <= 1'b1;
    @(posedge clk_sys);
    ds_wake_valid <= 1'b0;
    #1 chk(16'(ds_enter), 16'h0000);
    rd(ADDR_WAKE_CAUSE, 16'h0008);
    rd(ADDR_DS_CONTROL, 16'h0001);
    @(posedge clk_sys);
    resetn <= 1'b0;
    reset_kind <= 3'b010;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(ADDR_RESET_CAUSE, 16'h0080);
    rd(ADDR_SCRATCH0, 16'hA5A5);
    // deep sleep wake reset: only the scratch pair survives
    @(posedge clk_sys);
    resetn <= 1'b0;
    reset_kind <= DPPG_RST_DSW;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(ADDR_RESET_CAUSE, 16'h0400);
    rd(ADDR_SCRATCH1, 16'h5A5A);
    rd(ADDR_CLOCK_DIVIDE_CONTROL, 16'h0300);
    conclude;
  end
endmodule // test_doze_and_peripheral_power_gate
